// *** tpc_map.svh ***
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define TPC_OFS_TCTL 6'h00
`define TPC_OFS_TCNT 6'h04
`define TPC_OFS_P5DIR 6'h08
`define TPC_OFS_P6DIR 6'h0C
`define TPC_OFS_PRESC 6'h10
`define TPC_OFS_PDN 6'h14
`define TPC_OFS_OD 6'h18
`define TPC_OFS_PUP 6'h1C
`define TPC_OFS_WDCTL 6'h20
`define TPC_OFS_IMASK 6'h24
`define TPC_OFS_IFLAG 6'h28
`define TPC_OFS_ROPT 6'h2C
// ==========================================
// Reset values
`define TPC_RST_TCTL 8'hBF
`define TPC_RST_P5DIR 8'h0F
`define TPC_RST_P6DIR 8'hFF
`define TPC_RST_PRESC 8'hFF
`define TPC_RST_PDN 8'hFF
`define TPC_RST_OD 8'h00
`define TPC_RST_PUP 8'hFF
`define TPC_RST_WDCTL 8'h80
`define TPC_RST_ZERO 8'h00
// ==========================================
// Field positions and masks
`define TPC_RATIO_HI 2
`define TPC_PAB_BIT 3
`define TPC_EDGE_BIT 4
`define TPC_SRC_BIT 5
`define TPC_GIE_BIT 6
`define TPC_WDEN_BIT 7
`define TPC_EIS_BIT 6
`define TPC_ROC_BIT 4
`define TPC_WDCTL_MASK 8'hD0
`define TPC_P5DIR_MASK 8'h0F
`define TPC_PDN_MASK 8'hF7
`define TPC_IRQ_MASK 8'h07
`define TPC_FLG_OVF 0
`define TPC_FLG_CHG 1
`define TPC_FLG_EXT 2
// ==========================================
// Timing
`define TPC_CLK_HZ 40000000
`define TPC_WDT_PERIOD_US 18000
`define TPC_WDT_CYCLES ((`TPC_WDT_PERIOD_US / 1000) * (`TPC_CLK_HZ / 1000))
`define TPC_RESP_OKAY 2'h0
`define TPC_RESP_SLVERR 2'h2
`endif

// *** tpc_pkg.sv ***
`default_nettype none
package tpc_pkg;
  typedef logic [7:0] tpc_byte_t;
  typedef enum logic {
    TPC_SRC_CYCLE = 1'b0,
    TPC_SRC_PIN = 1'b1
  } tpc_src_t;
  typedef enum logic {
    TPC_CYC_DIV2 = 1'b0,
    TPC_CYC_DIV4 = 1'b1
  } tpc_cyc_t;
endpackage : tpc_pkg
`default_nettype wire

// *** tpc_timer_ctrl.sv ***
`include "tpc_map.svh"
`default_nettype none
// Operation
// - ratio field sets prescaler division
// - prescaler serves timer or watchdog only
// - external count on selected pin edge
// - source bit picks cycle clock or pin
// - cycle clock is Fosc/2 or Fosc/4
// - global flag follows mask/enable ops
// - timer write clears timer prescaler
// - watchdog clear/sleep clear counter, watchdog prescaler
// - prescaler is readable 8-bit down counter
// - direction bit 1 tristates, 0 drives
// - pull-down bits active low, bit3 unused
// - open-drain bit 1 per port-6 pin
// - pull-high bit 0 enables per pin
// - watchdog enable bit, writable anytime
// - pin-select bit routes external interrupt pin
// - option bit lets resistor pins read
// - mask bits enable three interrupt requests
// - global enable independent of mask bits
// - watchdog free-runs, timeout resets device
// - watchdog base period about 18 ms
// - overflow flag sticky until cleared
// - flag read is flags AND mask
// - timer control resets to all ones except 6
module tpc_timer_ctrl #(
  parameter int ADDR_W = 6,
  parameter int WDT_CYCLES = `TPC_WDT_CYCLES
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core instruction strobes
  input wire logic enable_irqs_op,
  input wire logic mask_irqs_op,
  input wire logic return_from_irq_op,
  input wire logic irq_entry,
  input wire logic watchdog_clear_op,
  input wire logic sleep_op,
  input wire logic cycle_divider_option,
  // Pins
  input wire logic count_pin,
  input wire logic [7:0] port6_in,
  input wire logic [1:0] option_pins,
  // Pin controls
  output logic [3:0] port5_oe_n,
  output logic [7:0] port6_oe_n,
  output logic [2:0] port5_pulldown_n,
  output logic [3:0] port6_pulldown_n,
  output logic [7:0] port6_open_drain,
  output logic [7:0] port6_pullup_n,
  output logic ext_irq_pin_select,
  // Status
  output logic irq_request,
  output logic watchdog_reset
);
  // ==========================================
  // State
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next, w_lane_reg, w_lane_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_data_reg, w_data_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, pin_prev_reg, pin_prev_next, wdrst_reg, wdrst_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next, cyc_div_reg, cyc_div_next;
  logic [31:0] rdata_reg, rdata_next, wdt_cnt_reg, wdt_cnt_next;
  tpc_pkg::tpc_byte_t tctl_reg, tctl_next, tcnt_reg, tcnt_next, p5dir_reg, p5dir_next, p6dir_reg, p6dir_next;
  tpc_pkg::tpc_byte_t presc_reg, presc_next, pdn_reg, pdn_next, od_reg, od_next, pup_reg, pup_next;
  tpc_pkg::tpc_byte_t wdctl_reg, wdctl_next, imask_reg, imask_next, iflag_reg, iflag_next;
  logic [7:0] p6_prev_reg, p6_prev_next;
  // ==========================================
  // Decode
  logic wr_fire, rd_fire, wr_en, tcnt_wr, prescaler_assign, gie, cyc_tick, pin_edge, src_ev, wd_clear, rd_hit;
  logic base_to, presc_in, presc_out, tmr_inc, wdt_to;
  logic [ADDR_W-1:0] wa;
  logic [8:0] tmr_mask9;
  logic [7:0] tmr_mask, wdt_mask, ratio_mask, presc_dec;
  logic [2:0] ratio;
  tpc_pkg::tpc_byte_t rd_val;
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign wr_en = wr_fire && w_lane_reg;
  assign wa = aw_addr_reg;
  assign tcnt_wr = wr_en && (wa == `TPC_OFS_TCNT);
  assign prescaler_assign = tctl_reg[`TPC_PAB_BIT];
  assign gie = tctl_reg[`TPC_GIE_BIT];
  assign ratio = tctl_reg[`TPC_RATIO_HI:0];
  assign wd_clear = watchdog_clear_op || sleep_op;
  // ==========================================
  // Bus channels
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `TPC_RESP_OKAY;
      if (wa > `TPC_OFS_IFLAG || wa[1:0] != 2'h0 || wa == `TPC_OFS_PRESC) begin
        bresp_next = `TPC_RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_val};
      rresp_next = rd_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end
  // Read mux; unmapped reads zero with SLVERR
  always_comb begin
    rd_val = `TPC_RST_ZERO;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `TPC_OFS_TCTL: rd_val = tctl_reg;
      `TPC_OFS_TCNT: rd_val = tcnt_reg;
      `TPC_OFS_P5DIR: rd_val = p5dir_reg;
      `TPC_OFS_P6DIR: rd_val = p6dir_reg;
      `TPC_OFS_PRESC: rd_val = presc_reg;
      `TPC_OFS_PDN: rd_val = pdn_reg;
      `TPC_OFS_OD: rd_val = od_reg;
      `TPC_OFS_PUP: rd_val = pup_reg;
      `TPC_OFS_WDCTL: rd_val = wdctl_reg;
      `TPC_OFS_IMASK: rd_val = imask_reg;
      `TPC_OFS_IFLAG: rd_val = iflag_reg & imask_reg;
      `TPC_OFS_ROPT: rd_val = wdctl_reg[`TPC_ROC_BIT] ? {6'h00, option_pins} : `TPC_RST_ZERO;
      default: rd_hit = 1'b0;
    endcase
  end
  // ==========================================
  // Counting path
  always_comb begin
    cyc_div_next = cyc_div_reg + 2'h1;
    if (cycle_divider_option == tpc_pkg::TPC_CYC_DIV2) begin
      cyc_tick = cyc_div_reg[0];
    end else begin
      cyc_tick = &cyc_div_reg;
    end
    // rising when edge bit set, else falling
    pin_prev_next = count_pin;
    pin_edge = tctl_reg[`TPC_EDGE_BIT] ? (count_pin && !pin_prev_reg) : (!count_pin && pin_prev_reg);
    if (tctl_reg[`TPC_SRC_BIT] == tpc_pkg::TPC_SRC_PIN) begin
      src_ev = pin_edge;
    end else begin
      src_ev = cyc_tick;
    end
    // watchdog base runs regardless of sleep
    base_to = (wdt_cnt_reg == 32'(WDT_CYCLES - 1));
    wdt_cnt_next = base_to ? 32'h00000000 : wdt_cnt_reg + 32'h00000001;
    tmr_mask9 = (9'h002 << ratio) - 9'h001;
    tmr_mask = tmr_mask9[7:0];
    wdt_mask = 8'((9'h001 << ratio) - 9'h001);
    ratio_mask = prescaler_assign ? wdt_mask : tmr_mask;
    presc_in = prescaler_assign ? base_to : src_ev;
    presc_dec = presc_reg - 8'h01;
    presc_out = presc_in && ((presc_dec & ratio_mask) == ratio_mask);
    presc_next = presc_in ? presc_dec : presc_reg;
    tmr_inc = prescaler_assign ? src_ev : presc_out;
    wdt_to = wdctl_reg[`TPC_WDEN_BIT] && (prescaler_assign ? presc_out : base_to);
    tcnt_next = tmr_inc ? tcnt_reg + 8'h01 : tcnt_reg;
    if (tcnt_wr) begin
      tcnt_next = w_data_reg;
      if (!prescaler_assign) begin
        presc_next = `TPC_RST_PRESC;
      end
    end
    if (wd_clear) begin
      wdt_cnt_next = 32'h00000000;
      if (prescaler_assign) begin
        presc_next = `TPC_RST_PRESC;
      end
    end
    // time-out drives a device reset pulse
    wdrst_next = wdt_to && !wd_clear;
  end
  // ==========================================
  // Control registers and flags
  always_comb begin
    tctl_next = tctl_reg;
    p5dir_next = p5dir_reg;
    p6dir_next = p6dir_reg;
    pdn_next = pdn_reg;
    od_next = od_reg;
    pup_next = pup_reg;
    wdctl_next = wdctl_reg;
    imask_next = imask_reg;
    iflag_next = iflag_reg;
    p6_prev_next = port6_in;
    if (wr_en) begin
      unique case (wa)
        `TPC_OFS_TCTL: tctl_next = w_data_reg;
        // only low nibble for port 5
        `TPC_OFS_P5DIR: p5dir_next = w_data_reg & `TPC_P5DIR_MASK;
        `TPC_OFS_P6DIR: p6dir_next = w_data_reg;
        `TPC_OFS_PDN: pdn_next = w_data_reg & `TPC_PDN_MASK;
        `TPC_OFS_OD: od_next = w_data_reg;
        `TPC_OFS_PUP: pup_next = w_data_reg;
        `TPC_OFS_WDCTL: wdctl_next = w_data_reg & `TPC_WDCTL_MASK;
        `TPC_OFS_IMASK: imask_next = w_data_reg & `TPC_IRQ_MASK;
        // Writes can only clear flags
        `TPC_OFS_IFLAG: iflag_next = iflag_reg & w_data_reg;
        default: ;
      endcase
    end
    if (mask_irqs_op || irq_entry) begin
      tctl_next[`TPC_GIE_BIT] = 1'b0;
    end else if (enable_irqs_op || return_from_irq_op) begin
      tctl_next[`TPC_GIE_BIT] = 1'b1;
    end
    if (tmr_inc && !tcnt_wr && tcnt_reg == 8'hFF) begin
      iflag_next[`TPC_FLG_OVF] = 1'b1;
    end
    if (port6_in != p6_prev_reg) begin
      iflag_next[`TPC_FLG_CHG] = 1'b1;
    end
    // external pin path masked unless selected
    if (wdctl_reg[`TPC_EIS_BIT] && p6_prev_reg[0] && !port6_in[0]) begin
      iflag_next[`TPC_FLG_EXT] = 1'b1;
    end
  end
  // ==========================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= `TPC_RST_ZERO;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TPC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `TPC_RESP_OKAY;
      tctl_reg <= `TPC_RST_TCTL;
      tcnt_reg <= `TPC_RST_ZERO;
      p5dir_reg <= `TPC_RST_P5DIR;
      p6dir_reg <= `TPC_RST_P6DIR;
      presc_reg <= `TPC_RST_PRESC;
      pdn_reg <= `TPC_RST_PDN;
      od_reg <= `TPC_RST_OD;
      pup_reg <= `TPC_RST_PUP;
      wdctl_reg <= `TPC_RST_WDCTL;
      imask_reg <= `TPC_RST_ZERO;
      iflag_reg <= `TPC_RST_ZERO;
      cyc_div_reg <= 2'h0;
      wdt_cnt_reg <= 32'h00000000;
      pin_prev_reg <= count_pin;
      p6_prev_reg <= port6_in;
      wdrst_reg <= 1'b0;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      tctl_reg <= tctl_next;
      tcnt_reg <= tcnt_next;
      p5dir_reg <= p5dir_next;
      p6dir_reg <= p6dir_next;
      presc_reg <= presc_next;
      pdn_reg <= pdn_next;
      od_reg <= od_next;
      pup_reg <= pup_next;
      wdctl_reg <= wdctl_next;
      imask_reg <= imask_next;
      iflag_reg <= iflag_next;
      cyc_div_reg <= cyc_div_next;
      wdt_cnt_reg <= wdt_cnt_next;
      pin_prev_reg <= pin_prev_next;
      p6_prev_reg <= p6_prev_next;
      wdrst_reg <= wdrst_next;
    end
  end
  // ==========================================
  // Pin controls
  // direction bit 1 means tristate
  assign port5_oe_n = p5dir_reg[3:0];
  assign port6_oe_n = p6dir_reg;
  assign port5_pulldown_n = pdn_reg[2:0];
  assign port6_pulldown_n = pdn_reg[7:4];
  assign port6_open_drain = od_reg;
  assign port6_pullup_n = pup_reg;
  assign ext_irq_pin_select = wdctl_reg[`TPC_EIS_BIT];
  // individual enables gated by global flag
  assign irq_request = gie && |(iflag_reg & imask_reg);
  assign watchdog_reset = wdrst_reg;
  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence tcnt_write_s;
    tcnt_wr && !prescaler_assign;
  endsequence
  sequence presc_fresh_s;
    presc_reg == `TPC_RST_PRESC;
  endsequence
  gie_mask_a: assert property ((mask_irqs_op || irq_entry) |=> !gie)
    else $error("global flag not cleared");
  gie_set_a: assert property (enable_irqs_op && !mask_irqs_op && !irq_entry |=> gie)
    else $error("global flag not set");
  presc_tmr_clear_a: assert property (tcnt_write_s |=> presc_fresh_s)
    else $error("prescaler kept on timer write");
  presc_wdt_clear_a: assert property (wd_clear && prescaler_assign |=> presc_fresh_s and (wdt_cnt_reg == 32'h00000000))
    else $error("watchdog clear incomplete");
  tmr_wrap_a: assert property (tmr_inc && !tcnt_wr && tcnt_reg == 8'hFF |=> tcnt_reg == 8'h00
    && iflag_reg[`TPC_FLG_OVF])
    else $error("timer wrap wrong");
  flag_read_a: assert property (rd_fire && s_axi_araddr == `TPC_OFS_IFLAG
    |=> rdata_reg[7:0] == $past(iflag_reg & imask_reg))
    else $error("flag read not masked");
  ovf_sticky_a: assert property (iflag_reg[`TPC_FLG_OVF] && !wr_en |=> iflag_reg[`TPC_FLG_OVF])
    else $error("overflow flag dropped");
  wdt_reset_a: assert property (wdt_to && !wd_clear |=> watchdog_reset ##1 !wdt_to || watchdog_reset)
    else $error("time-out gave no reset");
  wdt_off_a: assert property (!wdctl_reg[`TPC_WDEN_BIT] |=> !watchdog_reset)
    else $error("reset while disabled");
  ratio_tmr_a: assert property (!prescaler_assign && ratio == 3'h0 && src_ev && !tcnt_wr
    && presc_reg[0] == 1'b0 |=> tcnt_reg == $past(tcnt_reg) + 8'h01)
    else $error("ratio 1:2 step missed");
  ext_edge_a: assert property (!wdctl_reg[`TPC_EIS_BIT] && !iflag_reg[`TPC_FLG_EXT] |=> !iflag_reg[`TPC_FLG_EXT])
    else $error("external flag while masked");
endmodule : tpc_timer_ctrl
`default_nettype wire

// *** tpc_pin_model.sv ***
`default_nettype none
module tpc_pin_model #(
  // Bit set where the option resistor to ground is fitted
  parameter logic [1:0] REX_FITTED = 2'h1
) (
  // Clock
  input wire logic aclk,
  // Controls from the block
  input wire logic [7:0] port6_pullup_n,
  // Pin levels into the block
  output var logic count_pin,
  output var logic [7:0] port6_in,
  output logic [1:0] option_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] churn = 8'h00;
  // ==========================================
  // Option pins
  // fitted reads low; the bench may refit
  logic [1:0] rex = REX_FITTED;
  assign option_pins = ~rex;
  // ==========================================
  // Port 6 levels
  // A released pin without pull-high never holds its last value
  always_ff @(posedge aclk) begin
    churn <= ~churn;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port6_in[i] = ext_en[i] ? ext_val[i] : (port6_pullup_n[i] ? churn[i] : 1'h1);
    end
  end
  task automatic set_port6(input logic [7:0] v);
    @(posedge aclk);
    ext_val <= v;
    repeat (3) @(posedge aclk);
  endtask : set_port6
  // ==========================================
  // Count pin
  initial begin
    count_pin = 1'h0;
  end
  // one pin transition
  // Each level is held several cycles so that the block's edge detector sees it
  task automatic count_edge(input logic lvl);
    @(posedge aclk);
    count_pin <= lvl;
    repeat (3) @(posedge aclk);
  endtask : count_edge
endmodule : tpc_pin_model
`default_nettype wire

// *** tpc_timer_ctrl_bench.sv ***
`include "tpc_map.svh"
`default_nettype none
module tpc_timer_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic cdo = 1'h0;
  logic ce = 1'h1;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic wd_clr = 1'h0;
  logic sleep = 1'h0;
  logic [3:0] ops = 4'h0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, cnt_pin, ext_sel, irq, wd_rst;
  logic [1:0] bresp, rresp, opt;
  logic [31:0] rdata;
  logic [7:0] p6_in, p6_oe_n, p6_od, p6_pu_n;
  logic [3:0] p5_oe_n, p6_pd_n;
  logic [2:0] p5_pd_n;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // ==========================================
  // Clock and instances
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end
  tpc_timer_ctrl #(.WDT_CYCLES(16)) tpc_timer_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .enable_irqs_op(ops[0]), .mask_irqs_op(ops[1]), .return_from_irq_op(ops[2]),
    .irq_entry(ops[3]), .watchdog_clear_op(wd_clr), .sleep_op(sleep),
    .cycle_divider_option(cdo), .count_pin(cnt_pin), .port6_in(p6_in), .option_pins(opt),
    .port5_oe_n(p5_oe_n), .port6_oe_n(p6_oe_n), .port5_pulldown_n(p5_pd_n),
    .port6_pulldown_n(p6_pd_n), .port6_open_drain(p6_od), .port6_pullup_n(p6_pu_n),
    .ext_irq_pin_select(ext_sel), .irq_request(irq), .watchdog_reset(wd_rst)
  );
  tpc_pin_model #(.REX_FITTED(2'h1)) tpc_pin_model_i (
    .aclk(aclk), .port6_pullup_n(p6_pu_n), .count_pin(cnt_pin), .port6_in(p6_in),
    .option_pins(opt)
  );
  // ==========================================
  // Tasks
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1));
    bready <= 1'h0;
    chk(bresp, er, "write response");
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1));
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk(r, `TPC_RESP_OKAY, "read response");
  endtask : rc
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    wr(a, d, `TPC_RESP_OKAY);
  endtask : w
  task automatic edges(input int n);
    repeat (n) begin
      tpc_pin_model_i.count_edge(1'h1);
      tpc_pin_model_i.count_edge(1'h0);
    end
  endtask : edges
  task automatic op(input int k);
    @(posedge aclk);
    ops <= 4'h1 << k;
    @(posedge aclk);
    ops <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask : op
  // Two reads whose address edges lie exactly 256 cycles apart
  task automatic rate(input logic [7:0] tc, input logic [7:0] exp);
    logic [31:0] a, b;
    logic [1:0] r;
    logic [7:0] dif;
    w(`TPC_OFS_TCTL, tc);
    rd(`TPC_OFS_TCNT, a, r);
    repeat (253) @(posedge aclk);
    rd(`TPC_OFS_TCNT, b, r);
    dif = b[7:0] - a[7:0];
    chk(dif, exp, "timer rate");
  endtask : rate
  task automatic wait_wd();
    do @(posedge aclk); while (wd_rst !== 1'h1);
  endtask : wait_wd
  task automatic wd_gap(input logic [7:0] tc, input int exp);
    int t0;
    w(`TPC_OFS_TCTL, tc);
    wait_wd();
    wait_wd();
    t0 = cyc;
    wait_wd();
    chk(cyc - t0, exp, "watchdog period");
  endtask : wd_gap
  task automatic quiet(input logic clr_on);
    int n;
    n = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge aclk);
      if (i > 4 && wd_rst === 1'h1) n++;
      wd_clr <= clr_on && (i % 20 == 0);
      sleep <= clr_on && (i % 20 == 10);
    end
    chk(n, 0, "watchdog quiet");
  endtask : quiet
  // ==========================================
  // Watchdog on the run
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
  // ==========================================
  // Tests
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rc(`TPC_OFS_PRESC, 32'hFF);
    rc(`TPC_OFS_TCTL, 32'hBF);
    rc(`TPC_OFS_P5DIR, 32'h0F);
    rc(`TPC_OFS_P6DIR, 32'hFF);
    rc(`TPC_OFS_PDN, 32'hFF);
    rc(`TPC_OFS_OD, 32'h00);
    rc(`TPC_OFS_PUP, 32'hFF);
    rc(`TPC_OFS_WDCTL, 32'h80);
    rc(`TPC_OFS_IMASK, 32'h00);
    chk({p5_oe_n, p6_oe_n, p5_pd_n, p6_pd_n}, {4'hF, 8'hFF, 3'h7, 4'hF}, "pins at reset");
    chk({p6_od, p6_pu_n, ext_sel, irq}, {8'h00, 8'hFF, 1'h0, 1'h0}, "pins at reset");
    w(`TPC_OFS_P5DIR, 8'hFF);
    rc(`TPC_OFS_P5DIR, 32'h0F);
    wstrb <= 4'h0;
    w(`TPC_OFS_P5DIR, 8'h00);
    wstrb <= 4'hF;
    rc(`TPC_OFS_P5DIR, 32'h0F);
    w(`TPC_OFS_WDCTL, 8'hFF);
    rc(`TPC_OFS_WDCTL, 32'hD0);
    rc(`TPC_OFS_ROPT, 32'h02);
    tpc_pin_model_i.rex <= 2'h2;
    rc(`TPC_OFS_ROPT, 32'h01);
    w(`TPC_OFS_WDCTL, 8'h80);
    rc(`TPC_OFS_ROPT, 32'h00);
    w(`TPC_OFS_IMASK, 8'hFF);
    rc(`TPC_OFS_IMASK, 32'h07);
    rc(`TPC_OFS_IFLAG, 32'h00);
    w(`TPC_OFS_P5DIR, 8'h0A);
    w(`TPC_OFS_P6DIR, 8'h96);
    w(`TPC_OFS_PDN, 8'hA5);
    w(`TPC_OFS_OD, 8'h3C);
    w(`TPC_OFS_PUP, 8'h5A);
    chk({p5_oe_n, p6_oe_n}, {4'hA, 8'h96}, "direction pins");
    chk({p5_pd_n, p6_pd_n}, {3'h5, 4'hA}, "pull-down pins");
    chk({p6_od, p6_pu_n}, {8'h3C, 8'h5A}, "drain and pull-high pins");
    wr(`TPC_OFS_PRESC, 8'h12, `TPC_RESP_SLVERR);
    wr(6'h01, 8'h12, `TPC_RESP_SLVERR);
    rd(6'h3C, d, r);
    chk({r, d}, {`TPC_RESP_SLVERR, 32'h0}, "unmapped read");
    // Overflow flag, masking and the global enable
    w(`TPC_OFS_IFLAG, 8'h00);
    w(`TPC_OFS_TCTL, 8'h38);
    w(`TPC_OFS_TCNT, 8'hFE);
    edges(2);
    rc(`TPC_OFS_TCNT, 32'h00);
    rc(`TPC_OFS_IFLAG, 32'h01);
    w(`TPC_OFS_IMASK, 8'h00);
    rc(`TPC_OFS_IFLAG, 32'h00);
    op(0);
    chk(irq, 1'h0, "irq with mask clear");
    w(`TPC_OFS_IMASK, 8'h01);
    chk(irq, 1'h1, "irq enabled");
    rc(`TPC_OFS_IFLAG, 32'h01);
    rc(`TPC_OFS_TCTL, 32'h78);
    for (int k = 1; k < 4; k++) begin
      op(k);
      chk(irq, k == 2, "irq after op");
      rc(`TPC_OFS_TCTL, (k == 2) ? 32'h78 : 32'h38);
    end
    // Count pin edge selection
    w(`TPC_OFS_TCNT, 8'h00);
    tpc_pin_model_i.count_edge(1'h1);
    rc(`TPC_OFS_TCNT, 32'h01);
    w(`TPC_OFS_TCTL, 8'h28);
    tpc_pin_model_i.count_edge(1'h0);
    rc(`TPC_OFS_TCNT, 32'h02);
    tpc_pin_model_i.count_edge(1'h1);
    rc(`TPC_OFS_TCNT, 32'h02);
    tpc_pin_model_i.count_edge(1'h0);
    // Clock enable low: a full pin pulse leaves the timer untouched
    ce <= 1'h0;
    edges(1);
    ce <= 1'h1;
    rc(`TPC_OFS_TCNT, 32'h03);
    // Timer prescale ratios on pin edges
    for (int k = 0; k < 8; k++) begin
      w(`TPC_OFS_TCTL, 8'h30 | k[7:0]);
      w(`TPC_OFS_TCNT, 8'h00);
      edges(4 << k);
      rc(`TPC_OFS_TCNT, 32'h02);
    end
    edges(1);
    rc(`TPC_OFS_PRESC, 32'hFE);
    w(`TPC_OFS_TCNT, 8'h00);
    rc(`TPC_OFS_PRESC, 32'hFF);
    edges(1);
    rc(`TPC_OFS_PRESC, 32'hFE);
    // Internal cycle clock rates
    for (int c = 0; c < 2; c++) begin
      cdo <= c[0];
      for (int s = 0; s < 4; s++) begin
        rate((s == 3) ? 8'h08 : s[7:0], 8'(256 / (2 << c) / ((s == 3) ? 1 : (2 << s))));
      end
    end
    // Watchdog periods, clearing and disabling
    wd_gap(8'h08, 16);
    wd_gap(8'h0A, 64);
    wd_gap(8'h07, 16);
    w(`TPC_OFS_TCTL, 8'h08);
    quiet(1'h1);
    w(`TPC_OFS_WDCTL, 8'h00);
    quiet(1'h0);
    // Port 6 change and the external interrupt pin
    w(`TPC_OFS_IMASK, 8'h07);
    w(`TPC_OFS_IFLAG, 8'h00);
    tpc_pin_model_i.set_port6(8'hDF);
    rc(`TPC_OFS_IFLAG, 32'h02);
    w(`TPC_OFS_WDCTL, 8'h40);
    chk(ext_sel, 1'h1, "pin select");
    w(`TPC_OFS_P6DIR, 8'h97);
    w(`TPC_OFS_IFLAG, 8'h00);
    tpc_pin_model_i.set_port6(8'hDE);
    rc(`TPC_OFS_IFLAG, 32'h06);
    w(`TPC_OFS_IMASK, 8'h04);
    rc(`TPC_OFS_IFLAG, 32'h04);
    w(`TPC_OFS_IMASK, 8'h07);
    w(`TPC_OFS_WDCTL, 8'h00);
    w(`TPC_OFS_IFLAG, 8'h00);
    tpc_pin_model_i.set_port6(8'hDF);
    tpc_pin_model_i.set_port6(8'hDE);
    rc(`TPC_OFS_IFLAG, 32'h02);
    tally_and_finish();
  end
endmodule : tpc_timer_ctrl_bench
`default_nettype wire
